// >>> logic/msec_ctrl.sv
`timescale 1ns/1ps
module msec_ctrl
  import msec_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // Pins
  input  wire logic              step_select_in,
  input  wire logic              enable_n_in,
  input  wire logic              enable_float_in,
  // Configuration
  input  wire logic              timeout_en,
  input  wire logic [NUM_CHAN-1:0] chan_en,
  input  wire logic [NUM_IMON-1:0] imon_en,
  input  wire logic              bus_valid_in,
  // Outputs
  output logic [SLOT_W-1:0]      mux_slot,
  output logic                   diff_out_oe,
  output logic                   bandgap_ref_output,
  output logic                   bus_valid_flag,
  output logic [2:0]             op_mode,
  output logic                   seq_restart
);

  logic       sel_lvl;
  logic       en_n_lvl;
  logic       en_f_lvl;
  msec_mode_t mode_reg;
  msec_mode_t mode_next;
  logic       sel_prev_reg;
  logic       sel_prev_next;
  logic       en_prev_reg;
  logic       en_prev_next;
  logic [HOLD_CNT_W-1:0] hold_cnt_reg;
  logic [HOLD_CNT_W-1:0] hold_cnt_next;
  logic [SLOT_W-1:0] slot_reg;
  logic [SLOT_W-1:0] slot_next;
  logic       oe_reg;
  logic       oe_next;
  logic       bg_reg;
  logic       bg_next;
  logic       bv_reg;
  logic       bv_next;
  logic       rs_reg;
  logic       rs_next;
  logic       sel_edge;
  logic       en_toggle;
  logic       restart;

  // Pin synchronisers
  msec_sync3 u_sync_sel (
    .mclk      (mclk),
    .rst       (rst),
    .clk_en    (clk_en),
    .pin_in    (step_select_in),
    .level_out (sel_lvl)
  );

  msec_sync3 u_sync_en (
    .mclk      (mclk),
    .rst       (rst),
    .clk_en    (clk_en),
    .pin_in    (enable_n_in),
    .level_out (en_n_lvl)
  );

  msec_sync3 u_sync_flt (
    .mclk      (mclk),
    .rst       (rst),
    .clk_en    (clk_en),
    .pin_in    (enable_float_in),
    .level_out (en_f_lvl)
  );

  // Next slot after cur among active ones
  function automatic logic [SLOT_W-1:0] next_slot(input logic [SLOT_W-1:0] cur,
                                                  input logic [NUM_CHAN-1:0] ce,
                                                  input logic [NUM_IMON-1:0] ie);
    logic [SLOT_W-1:0] s;
    logic              found;
    s     = SLOT_HIZ;
    found = 1'b0;
    for (int i = 1; i <= int'(SLOT_RGND); i++) begin
      if (!found && (i > cur)) begin
        if (i < SLOT_IM1) begin
          if (ce[(i - 1) / 2]) begin
            s     = SLOT_W'(i);
            found = 1'b1;
          end
        end else if (i < SLOT_RGND) begin
          if (ie[i - SLOT_IM1]) begin
            s     = SLOT_W'(i);
            found = 1'b1;
          end
        end else begin
          s     = SLOT_W'(i);
          found = 1'b1;
        end
      end
    end
    return s;
  endfunction

  // Mode decode
  always_comb begin
    if (en_f_lvl) begin
      mode_next = MSEC_EN_LIMITED;
    end else if (en_n_lvl) begin
      mode_next = MSEC_EN_STANDBY;
    end else begin
      mode_next = MSEC_EN_FULL;
    end
  end

  // Edge and toggle detection
  always_comb begin
    sel_edge  = (sel_lvl != sel_prev_reg);
    en_toggle = (en_n_lvl != en_prev_reg);
    if (en_f_lvl && (mode_reg != MSEC_EN_LIMITED)) begin
      en_toggle = 1'h1;
    end
  end

  // Sequence and timeout
  always_comb begin
    sel_prev_next = sel_lvl;
    en_prev_next  = en_n_lvl;
    hold_cnt_next = hold_cnt_reg;
    slot_next     = slot_reg;
    restart       = 1'b0;
    if (mode_reg != MSEC_EN_FULL || en_toggle) begin
      hold_cnt_next = '0;
      slot_next     = SLOT_HIZ;
      restart       = en_toggle;
    end else if (sel_edge) begin
      hold_cnt_next = '0;
      if (slot_reg == SLOT_RGND) begin
        slot_next = next_slot(SLOT_HIZ, chan_en, imon_en);
      end else begin
        slot_next = next_slot(slot_reg, chan_en, imon_en);
      end
    end else if (timeout_en) begin
      if (hold_cnt_reg >= HOLD_CNT_W'(HOLD_TIMEOUT_CYC)) begin
        slot_next     = SLOT_HIZ;
        hold_cnt_next = '0;
        restart       = (slot_reg != SLOT_HIZ);
      end else begin
        hold_cnt_next = hold_cnt_reg + 1'b1;
      end
    end else begin
      hold_cnt_next = '0;
    end
  end

  // Output drive
  always_comb begin
    oe_next = (mode_next == MSEC_EN_FULL) && (slot_next != SLOT_HIZ);
    bg_next = (mode_next != MSEC_EN_STANDBY);
    bv_next = (mode_next != MSEC_EN_STANDBY) && bus_valid_in;
    rs_next = restart;
  end

  // Mode register
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_reg <= MSEC_EN_STANDBY;
    end else if (clk_en) begin
      mode_reg <= mode_next;
    end
  end

  // Sequence registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_prev_reg <= 1'h0;
      en_prev_reg  <= 1'h0;
      hold_cnt_reg <= '0;
      slot_reg     <= SLOT_HIZ;
    end else if (clk_en) begin
      sel_prev_reg <= sel_prev_next;
      en_prev_reg  <= en_prev_next;
      hold_cnt_reg <= hold_cnt_next;
      slot_reg     <= slot_next;
    end
  end

  // Output registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      oe_reg <= 1'h0;
      bg_reg <= 1'h0;
      bv_reg <= 1'h0;
      rs_reg <= 1'h0;
    end else if (clk_en) begin
      oe_reg <= oe_next;
      bg_reg <= bg_next;
      bv_reg <= bv_next;
      rs_reg <= rs_next;
    end
  end

  // Ports straight from registers
  assign mux_slot           = slot_reg;
  assign diff_out_oe        = oe_reg;
  assign bandgap_ref_output = bg_reg;
  assign bus_valid_flag     = bv_reg;
  assign op_mode            = mode_reg;
  assign seq_restart        = rs_reg;

endmodule // msec_ctrl

// >>> logic/msec_pkg.sv
package msec_pkg;

  // Clock and timeout
  localparam int          CLK_PERIOD_PS   = 5000;
  localparam int          HOLD_TIMEOUT_NS = 45000;
  localparam int          HOLD_TIMEOUT_CYC = (HOLD_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
  localparam int          HOLD_CNT_W      = 14;

  // Channel layout
  localparam int          NUM_CHAN        = 4;
  localparam int          NUM_IMON        = 2;
  localparam int          SLOT_W          = 4;
  localparam logic [3:0]  CHAN_EN_RST     = 4'hF;
  localparam logic [1:0]  IMON_EN_RST     = 2'h3;

  // Mux slot codes
  localparam logic [SLOT_W-1:0] SLOT_HIZ  = 4'h0;
  localparam logic [SLOT_W-1:0] SLOT_BUS1 = 4'h1;
  localparam logic [SLOT_W-1:0] SLOT_IM1  = 4'h9;
  localparam logic [SLOT_W-1:0] SLOT_RGND = 4'hB;

  // Enable pin level codes
  typedef enum logic [2:0] {
    MSEC_EN_FULL    = 3'b001,
    MSEC_EN_LIMITED = 3'b010,
    MSEC_EN_STANDBY = 3'b100
  } msec_mode_t;

endpackage

// >>> logic/msec_sync3.sv
`timescale 1ns/1ps
module msec_sync3 (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic clk_en,
  // Pin side
  input  wire logic pin_in,
  // Filtered level
  output logic      level_out
);

  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic       level_reg;
  logic       level_next;

  always_comb begin
    sync_next  = {sync_reg[1:0], pin_in};
    level_next = level_reg;
    if (sync_reg[2] == sync_reg[1]) begin
      level_next = sync_reg[2];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_reg  <= 3'h0;
      level_reg <= 1'b0;
    end else if (clk_en) begin
      sync_reg  <= sync_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule // msec_sync3

// >>> test/msec_ctrl_props.sv
`timescale 1ns/1ps
module msec_ctrl_props
  import msec_pkg::*;
(
  // Clock and reset
  input logic       mclk,
  input logic       rst,
  // Watched ports
  input logic       step_select_in,
  input logic       timeout_en,
  input logic [3:0] mux_slot,
  input logic       diff_out_oe,
  input logic       bandgap_ref_output,
  input logic       bus_valid_flag,
  input logic [2:0] op_mode,
  input logic       seq_restart
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic full;
  int   held_reg;
  assign full = op_mode == MSEC_EN_FULL;
  // Cycles of steady select level while timing is armed
  always_ff @(posedge mclk)
    held_reg <= (rst || !timeout_en || !full || $changed(step_select_in)) ? 0 : held_reg + 1;
  property p_oe; diff_out_oe == (full && mux_slot != SLOT_HIZ); endproperty
  a_oe: assert property (p_oe) else $error("oe wrong");
  property p_hiz; !full && !$past(full) |-> mux_slot == SLOT_HIZ; endproperty
  a_hiz: assert property (p_hiz) else $error("slot not idle");
  property p_mode; $onehot(op_mode); endproperty
  a_mode: assert property (p_mode) else $error("mode code");
  property p_bg; $stable(op_mode) |-> bandgap_ref_output == (op_mode != MSEC_EN_STANDBY);
  endproperty
  a_bg: assert property (p_bg) else $error("reference flag");
  property p_sb; op_mode == MSEC_EN_STANDBY && $stable(op_mode) |-> !bus_valid_flag; endproperty
  a_sb: assert property (p_sb) else $error("valid in standby");
  property p_ord;
    $changed(mux_slot) && mux_slot != 0 |-> mux_slot > $past(mux_slot) || $past(mux_slot) == 11;
  endproperty
  a_ord: assert property (p_ord) else $error("slot order");
  property p_pls; seq_restart |=> !seq_restart; endproperty
  a_pls: assert property (p_pls) else $error("restart width");
  property p_tmin;
    $past(mux_slot) != 0 && mux_slot == 0 && full && $past(full) |-> held_reg >= HOLD_TIMEOUT_CYC;
  endproperty
  a_tmin: assert property (p_tmin) else $error("early return");
  property p_tmax; held_reg > HOLD_TIMEOUT_CYC + 12 |-> mux_slot == SLOT_HIZ; endproperty
  a_tmax: assert property (p_tmax) else $error("no timeout");
  c_to: cover property ($fell(|mux_slot) && full);
  c_lim: cover property (op_mode == MSEC_EN_LIMITED);
  c_rs: cover property (seq_restart);
endmodule // msec_ctrl_props
bind msec_ctrl msec_ctrl_props u_props (.*);

// >>> test/msec_host.sv
`timescale 1ns/1ps
module msec_host (
  // Clock and request
  input  wire logic mclk,
  input  wire logic step_req,
  // Pin
  output logic      step_select_in
);
  initial step_select_in = 1'b0;
  // One level change per step, held between steps
  always @(posedge mclk) if (step_req) step_select_in <= ~step_select_in;
endmodule // msec_host

// >>> test/msec_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end
module msec_ctrl_test;
  import msec_pkg::*;
  logic        mclk = 0, rst = 1, clk_en = 1, step_req = 0, step_select_in;
  logic        enable_n_in = 0, enable_float_in = 0, timeout_en = 0, bus_valid_in = 0;
  logic [3:0]  chan_en = 4'hF, mux_slot, last = 0, cur = 0, want, q[$];
  logic [1:0]  imon_en = 2'h3;
  logic        diff_out_oe, bandgap_ref_output, bus_valid_flag, seq_restart;
  logic [2:0]  op_mode;
  logic [31:0] rnd = 32'h093D6EAA;
  int          error_cnt = 0, n_checks = 0, cyc = 0, rs_cnt = 0;
  always #2.5 mclk = ~mclk;
  msec_host host (
    .mclk           (mclk),
    .step_req       (step_req),
    .step_select_in (step_select_in)
  );
  msec_ctrl dut (
    .mclk               (mclk),
    .rst                (rst),
    .clk_en             (clk_en),
    .step_select_in     (step_select_in),
    .enable_n_in        (enable_n_in),
    .enable_float_in    (enable_float_in),
    .timeout_en         (timeout_en),
    .chan_en            (chan_en),
    .imon_en            (imon_en),
    .bus_valid_in       (bus_valid_in),
    .mux_slot           (mux_slot),
    .diff_out_oe        (diff_out_oe),
    .bandgap_ref_output (bandgap_ref_output),
    .bus_valid_flag     (bus_valid_flag),
    .op_mode            (op_mode),
    .seq_restart        (seq_restart)
  );
  function automatic logic [31:0] xorshift(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [3:0] nxt(logic [3:0] s);
    do s = (s >= 11) ? 4'h1 : s + 4'h1;
    while (s < 9 ? !chan_en[(s - 1) / 2] : s < 11 && !imon_en[s - 9]);
    return s;
  endfunction
  task automatic step(bit ok);
    step_req <= 1;
    @(posedge mclk) step_req <= 0;
    if (ok && nxt(cur) != cur) begin
      cur = nxt(cur);
      q.push_back(cur);
    end
    repeat (8) @(posedge mclk);
  endtask
  task automatic home();
    q.push_back(SLOT_HIZ);
    cur = 0;
  endtask
  task automatic results();
    if (q.size() != 0) begin
      error_cnt++;
    end
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (!rst && seq_restart) begin
      rs_cnt++;
    end
    if (!rst && mux_slot !== last) begin
      last = mux_slot;
      want = q.size() ? q.pop_front() : 4'hX;
      `CHK(mux_slot, want)
      `CHK(diff_out_oe, want != SLOT_HIZ)
    end
    if (cyc > 40000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 0;
    repeat (12) @(posedge mclk);
    `CHK(op_mode, MSEC_EN_FULL)
    for (int p = 0; p < 3; p++) begin
      rnd = xorshift(rnd);
      chan_en <= rnd[3:0];
      imon_en <= rnd[5:4];
      bus_valid_in <= rnd[6];
      @(posedge mclk);
      repeat (13) step(1);
      `CHK(bus_valid_flag, bus_valid_in)
    end
    for (int t = 0; t < 2; t++) begin
      timeout_en <= t[0];
      @(posedge mclk);
      step(1);
      repeat (8980) @(posedge mclk);
      `CHK(mux_slot, cur)
      if (t) home();
      repeat (120) @(posedge mclk);
    end
    `CHK(rs_cnt, 1)
    step(1);
    enable_n_in <= 1;
    bus_valid_in <= 1;
    home();
    repeat (12) @(posedge mclk);
    `CHK(op_mode, MSEC_EN_STANDBY)
    `CHK(bandgap_ref_output, 1'b0)
    `CHK(bus_valid_flag, 1'b0)
    `CHK(rs_cnt, 2)
    step(0);
    enable_float_in <= 1;
    repeat (12) @(posedge mclk);
    `CHK(op_mode, MSEC_EN_LIMITED)
    `CHK(bandgap_ref_output, 1'b1)
    `CHK(bus_valid_flag, 1'b1)
    `CHK(rs_cnt, 3)
    step(0);
    `CHK(mux_slot, SLOT_HIZ)
    `CHK(diff_out_oe, 1'b0)
    enable_float_in <= 0;
    enable_n_in <= 0;
    repeat (12) @(posedge mclk);
    `CHK(rs_cnt, 4)
    step(1);
    results();
  end
endmodule // msec_ctrl_test
